// >>> bar_map.svh
// Register offsets, field positions and fixed values of the bridge auxiliary register bank.
`ifndef BAR_MAP_SVH
`define BAR_MAP_SVH

// Byte offsets of the registers within the 4 KB register page.
`define BAR_OFF_HOST_ERR 12'h040
`define BAR_OFF_ERR_INFO 12'h044
`define BAR_OFF_PCI_ERR 12'h048
`define BAR_OFF_FBB 12'h05C
`define BAR_OFF_IO_WIN 12'h060
`define BAR_OFF_CFG_ADDR 12'h064
`define BAR_OFF_CFG_DATA 12'h068
`define BAR_OFF_PIO_DATA 12'h06C
`define BAR_OFF_PMEM_DATA 12'h070
`define BAR_OFF_FEATURE 12'h7B4
`define BAR_OFF_HOST_MASK 12'h800
`define BAR_OFF_PCI_MASK 12'h804
`define BAR_OFF_ARB_PRIO 12'h808
`define BAR_OFF_ARB_PERF 12'h80C
`define BAR_OFF_PCI_CTL 12'h810
`define BAR_OFF_PCI_STS 12'h814
`define BAR_OFF_MLT 12'h81C
`define BAR_OFF_FEAT_EN 12'h820
`define BAR_OFF_RD_HINT 12'h824
`define BAR_OFF_WR_HINT 12'h828
`define BAR_OFF_TLT 12'h830
`define BAR_OFF_MODE_CTL 12'h8F0
`define BAR_OFF_COMMAND 12'h8F4

// Fixed values, command codes and writable-bit masks.
`define BAR_FEATURE_VAL 32'h00000001
`define BAR_CMD_CLEAR 4'h3
`define BAR_CMD_RESET 4'h5
`define BAR_MODE_INCLUDE 2'h1
`define BAR_MODE_OFF 2'h0
`define BAR_WIN_LSB 23
`define BAR_WIN_MSB 27
`define BAR_WIN_WMASK 32'h7FFFFFFE
`define BAR_MLT_WMASK 8'hF8
`define BAR_TLT_WMASK 7'h7C
`define BAR_CTL_WMASK 7'h6F
`define BAR_CTL_SECRST 6
`define BAR_STS_FIXED 32'h00000120
`define BAR_STS_STICKY 8'h9F
`define BAR_ZERO32 32'h00000000

`endif

// >>> bar_pkg.sv
// Types shared by the bridge auxiliary register bank.
package bar_pkg;

    // Phase of the bus slave.
    typedef enum logic {
        BAR_PH_IDLE,
        BAR_PH_DATA
    } bar_phase_e;

    // Register offset within the page.
    typedef logic [11:0] bar_off_t;

endpackage

// >>> bar_regs.sv
// Bridge auxiliary register bank with AHB-Lite slave, error logs and I/O window forwarding.
`timescale 1ns/100ps
`default_nettype none
`include "bar_map.svh"

module bar_regs
    import bar_pkg::*;
(
    // Clock and reset.
    input wire logic clock,
    input wire logic rst,
    // AHB-Lite slave port.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Host-bus error report from the host interface.
    input wire logic host_err_evt,
    input wire logic host_err_self,
    input wire logic [31:0] host_err_addr,
    // PCI error report from the PCI interface.
    input wire logic pci_err_evt,
    input wire logic pci_err_self,
    input wire logic [31:0] pci_err_addr,
    // PCI status events: DPD, -, -, STA, RTA, RMA, SSE, DPE.
    input wire logic [7:0] pci_sts_evt,
    // Processor I/O access to be checked for forwarding.
    input wire logic io_req_valid,
    input wire logic [31:0] io_req_addr,
    output logic io_fwd_valid,
    output logic io_fwd_pci,
    // Control values driven to the rest of the bridge.
    output logic host_fbb_en,
    output logic [31:0] host_req_mask,
    output logic [31:0] pci_req_mask,
    output logic [6:0] arb_priority,
    output logic [1:0] arb_perf,
    output logic [6:0] pci_ctl,
    output logic [7:0] master_latency,
    output logic target_latency_en,
    output logic [6:0] target_latency,
    output logic [31:0] cfg_addr,
    // Data port write strobes: bit 0 config, bit 1 I/O, bit 2 memory.
    output logic [2:0] port_wr,
    output logic [31:0] port_wdata
);

    ////////////////////////////////////////////////////////////////////////////
    // Functions.

    // Picks the 8 MB window index out of a processor I/O address.
    function automatic logic [4:0] win_idx(input logic [31:0] a);
        win_idx = a[`BAR_WIN_MSB:`BAR_WIN_LSB];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Declarations.

    bar_phase_e ph_r, ph_nxt; // Bus slave phase.
    bar_off_t addr_r; // Offset captured in the address phase.
    logic wr_r; // Captured direction of the transfer.
    logic hready_r; // Registered ready.
    logic [31:0] rdata_r; // Registered read data.
    logic [31:0] host_log_r; // Host-bus error address log.
    logic [31:0] pci_log_r; // PCI error address log.
    logic [3:0] info_r; // Error information bits.
    logic fbb_r; // Fast back-to-back enable.
    logic [31:0] win_r; // Window enables.
    logic [31:0] cfg_addr_r; // Indirect address port.
    logic [31:0] cfg_data_r; // Configuration data port.
    logic [31:0] pio_data_r; // I/O data port.
    logic [31:0] pmem_data_r; // Memory data port.
    logic [31:0] hmask_r; // Host request mask.
    logic [31:0] pmask_r; // PCI request mask.
    logic [6:0] prio_r; // Arbiter priority select.
    logic [1:0] perf_r; // Performance arbitration mode.
    logic [6:0] ctl_r; // PCI coarse control.
    logic [7:0] sts_r; // Sticky PCI status bits.
    logic [7:0] mlt_r; // Master latency count.
    logic [7:0] tlt_r; // Target latency enable and count.
    logic [31:0] feat_r; // Bridge feature enables.
    logic [31:0] rhint_r; // Read hints.
    logic [31:0] whint_r; // Write hints.
    logic [1:0] mode_r; // Forwarding mode.
    logic [2:0] port_wr_r; // Data port write strobes.
    logic [31:0] port_wdata_r; // Last data written to a data port.
    logic fwd_valid_r; // Forwarding decision valid.
    logic fwd_r; // Forwarding decision.

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode.

    // An address phase is taken when the slave is selected, the transfer is NONSEQ or SEQ (htrans[1] set) and the bus is ready.
    wire take = hsel && htrans[1] && hready;
    // The write commits in the first data phase cycle while ready is held low.
    wire wr_go = (ph_r == BAR_PH_DATA) && wr_r && !hready_r;
    wire we_fbb = wr_go && (addr_r == `BAR_OFF_FBB);
    wire we_win = wr_go && (addr_r == `BAR_OFF_IO_WIN);
    wire we_caddr = wr_go && (addr_r == `BAR_OFF_CFG_ADDR);
    wire we_cdata = wr_go && (addr_r == `BAR_OFF_CFG_DATA);
    wire we_pio = wr_go && (addr_r == `BAR_OFF_PIO_DATA);
    wire we_pmem = wr_go && (addr_r == `BAR_OFF_PMEM_DATA);
    wire we_hmask = wr_go && (addr_r == `BAR_OFF_HOST_MASK);
    wire we_pmask = wr_go && (addr_r == `BAR_OFF_PCI_MASK);
    wire we_prio = wr_go && (addr_r == `BAR_OFF_ARB_PRIO);
    wire we_perf = wr_go && (addr_r == `BAR_OFF_ARB_PERF);
    wire we_ctl = wr_go && (addr_r == `BAR_OFF_PCI_CTL);
    wire we_sts = wr_go && (addr_r == `BAR_OFF_PCI_STS);
    wire we_mlt = wr_go && (addr_r == `BAR_OFF_MLT);
    wire we_feat = wr_go && (addr_r == `BAR_OFF_FEAT_EN);
    wire we_rhint = wr_go && (addr_r == `BAR_OFF_RD_HINT);
    wire we_whint = wr_go && (addr_r == `BAR_OFF_WR_HINT);
    wire we_tlt = wr_go && (addr_r == `BAR_OFF_TLT);
    wire we_mode = wr_go && (addr_r == `BAR_OFF_MODE_CTL);
    wire we_cmd = wr_go && (addr_r == `BAR_OFF_COMMAND);
    // Commands carried in the low nibble of a command register write.
    wire cmd_clear = we_cmd && (hwdata[3:0] == `BAR_CMD_CLEAR);
    wire cmd_reset = we_cmd && (hwdata[3:0] == `BAR_CMD_RESET);

    // Status word: fixed capability bits plus the sticky event bits.
    wire [31:0] sts_word = `BAR_STS_FIXED | {24'h000000, sts_r & `BAR_STS_STICKY};

    // Read selection; unmapped offsets and undefined bits read zero.
    wire [31:0] rd_mux =
        (addr_r == `BAR_OFF_HOST_ERR) ? host_log_r :
        (addr_r == `BAR_OFF_ERR_INFO) ? {28'h0000000, info_r} :
        (addr_r == `BAR_OFF_PCI_ERR) ? pci_log_r :
        (addr_r == `BAR_OFF_FBB) ? {31'h00000000, fbb_r} :
        (addr_r == `BAR_OFF_IO_WIN) ? (win_r & `BAR_WIN_WMASK) :
        (addr_r == `BAR_OFF_CFG_ADDR) ? cfg_addr_r :
        (addr_r == `BAR_OFF_CFG_DATA) ? cfg_data_r :
        (addr_r == `BAR_OFF_PIO_DATA) ? pio_data_r :
        (addr_r == `BAR_OFF_PMEM_DATA) ? pmem_data_r :
        (addr_r == `BAR_OFF_FEATURE) ? `BAR_FEATURE_VAL :
        (addr_r == `BAR_OFF_HOST_MASK) ? hmask_r :
        (addr_r == `BAR_OFF_PCI_MASK) ? pmask_r :
        (addr_r == `BAR_OFF_ARB_PRIO) ? {25'h0000000, prio_r} :
        (addr_r == `BAR_OFF_ARB_PERF) ? {30'h00000000, perf_r} :
        (addr_r == `BAR_OFF_PCI_CTL) ? {25'h0000000, ctl_r} :
        (addr_r == `BAR_OFF_PCI_STS) ? sts_word :
        (addr_r == `BAR_OFF_MLT) ? {24'h000000, mlt_r} :
        (addr_r == `BAR_OFF_FEAT_EN) ? feat_r :
        (addr_r == `BAR_OFF_RD_HINT) ? rhint_r :
        (addr_r == `BAR_OFF_WR_HINT) ? whint_r :
        (addr_r == `BAR_OFF_TLT) ? {24'h000000, tlt_r} :
        (addr_r == `BAR_OFF_MODE_CTL) ? {30'h00000000, mode_r} :
        `BAR_ZERO32;

    // Forwarding decision for the current processor I/O access.
    wire win_hit = win_r[win_idx(io_req_addr)] && (win_idx(io_req_addr) != 5'h00) && (win_idx(io_req_addr) != 5'h1F);
    wire fwd_nxt = io_req_valid && win_hit && (mode_r == `BAR_MODE_INCLUDE);

    ////////////////////////////////////////////////////////////////////////////
    // Bus slave.

    // Every transfer takes one wait state, so writes land before the next read is sampled.
    always_comb begin
        ph_nxt = ph_r;
        case (ph_r)
            BAR_PH_IDLE: begin
                if (take) begin
                    ph_nxt = BAR_PH_DATA;
                end
            end
            BAR_PH_DATA: begin
                // Leave when ready has been high for the closing edge, unless a new phase is taken.
                if (hready_r && !take) begin
                    ph_nxt = BAR_PH_IDLE;
                end
            end
            default: begin
                ph_nxt = BAR_PH_IDLE;
            end
        endcase
    end

    // Phase, captured address and direction.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ph_r <= BAR_PH_IDLE;
            addr_r <= 12'h000;
            wr_r <= 1'b0;
        end else begin
            ph_r <= ph_nxt;
            if (take) begin
                addr_r <= haddr[11:0];
                wr_r <= hwrite;
            end
        end
    end

    // Ready drops after each taken phase and returns one cycle later with read data.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            hready_r <= 1'b1;
            rdata_r <= `BAR_ZERO32;
        end else begin
            hready_r <= !take;
            if ((ph_r == BAR_PH_DATA) && !hready_r && !wr_r) begin
                rdata_r <= rd_mux;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Error logs.

    // Address logs load only from an error report, never from the bus.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            host_log_r <= `BAR_ZERO32;
            pci_log_r <= `BAR_ZERO32;
        end else begin
            if (host_err_evt && host_err_self) begin
                host_log_r <= host_err_addr;
            end
            if (pci_err_evt && pci_err_self) begin
                pci_log_r <= pci_err_addr;
            end
        end
    end

    // Information flags; a report in the clear cycle wins over the clear.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            info_r <= 4'h0;
        end else begin
            info_r[0] <= (host_err_evt && host_err_self) || (info_r[0] && !cmd_clear);
            info_r[1] <= (pci_err_evt && pci_err_self) || (info_r[1] && !cmd_clear);
            info_r[2] <= (host_err_evt && !host_err_self) || (info_r[2] && !cmd_clear);
            info_r[3] <= (pci_err_evt && !pci_err_self) || (info_r[3] && !cmd_clear);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Software control registers.

    // Plain read/write registers; hardwired bits are masked off on the way in.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            fbb_r <= 1'b0;
            win_r <= `BAR_ZERO32;
            cfg_addr_r <= `BAR_ZERO32;
            cfg_data_r <= `BAR_ZERO32;
            pio_data_r <= `BAR_ZERO32;
            pmem_data_r <= `BAR_ZERO32;
            hmask_r <= `BAR_ZERO32;
            pmask_r <= `BAR_ZERO32;
            prio_r <= 7'h00;
            perf_r <= 2'h0;
            mlt_r <= 8'h00;
            tlt_r <= 8'h00;
            feat_r <= `BAR_ZERO32;
            rhint_r <= `BAR_ZERO32;
            whint_r <= `BAR_ZERO32;
        end else begin
            if (we_fbb) fbb_r <= hwdata[0];
            if (we_win) win_r <= hwdata & `BAR_WIN_WMASK;
            if (we_caddr) cfg_addr_r <= hwdata;
            if (we_cdata) cfg_data_r <= hwdata;
            if (we_pio) pio_data_r <= hwdata;
            if (we_pmem) pmem_data_r <= hwdata;
            if (we_hmask) hmask_r <= hwdata;
            if (we_pmask) pmask_r <= hwdata;
            if (we_prio) prio_r <= hwdata[6:0];
            if (we_perf) perf_r <= hwdata[1:0];
            if (we_mlt) mlt_r <= hwdata[7:0] & `BAR_MLT_WMASK;
            if (we_tlt) tlt_r <= {hwdata[7], hwdata[6:0] & `BAR_TLT_WMASK};
            if (we_feat) feat_r <= hwdata;
            if (we_rhint) rhint_r <= hwdata;
            if (we_whint) whint_r <= hwdata;
        end
    end

    // Mode and PCI control; a reset command turns forwarding off and clears the PCI secondary reset bit.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mode_r <= `BAR_MODE_OFF;
            ctl_r <= 7'h00;
        end else if (cmd_reset) begin
            mode_r <= `BAR_MODE_OFF;
            ctl_r[`BAR_CTL_SECRST] <= 1'b0;
        end else begin
            if (we_mode) mode_r <= hwdata[1:0];
            if (we_ctl) ctl_r <= hwdata[6:0] & `BAR_CTL_WMASK;
        end
    end

    // Sticky PCI status; a new event beats a clearing write or command.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sts_r <= 8'h00;
        end else begin
            sts_r <= (pci_sts_evt & `BAR_STS_STICKY) | (sts_r & {8{!(we_sts || cmd_clear)}});
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs.

    // Data port strobes, forwarding decision and fixed bus answers.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            port_wr_r <= 3'h0;
            port_wdata_r <= `BAR_ZERO32;
            fwd_valid_r <= 1'b0;
            fwd_r <= 1'b0;
        end else begin
            port_wr_r <= {we_pmem, we_pio, we_cdata};
            if (we_cdata || we_pio || we_pmem) port_wdata_r <= hwdata;
            fwd_valid_r <= io_req_valid;
            fwd_r <= fwd_nxt;
        end
    end

    assign hreadyout = hready_r;
    assign hresp = 1'b0;
    assign hrdata = rdata_r;
    assign io_fwd_valid = fwd_valid_r;
    assign io_fwd_pci = fwd_r;
    assign host_fbb_en = fbb_r;
    assign host_req_mask = hmask_r;
    assign pci_req_mask = pmask_r;
    assign arb_priority = prio_r;
    assign arb_perf = perf_r;
    assign pci_ctl = ctl_r;
    assign master_latency = mlt_r;
    assign target_latency_en = tlt_r[7];
    assign target_latency = tlt_r[6:0];
    assign cfg_addr = cfg_addr_r;
    assign port_wr = port_wr_r;
    assign port_wdata = port_wdata_r;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions and cover points.

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // A read of the feature word returns one at the closing edge.
    a_feature_read: assert property (take && !hwrite && haddr[11:0] == `BAR_OFF_FEATURE |=> ##1 hrdata == 32'h00000001)
        else $error("feature word read not one");
    a_window_ends_zero: assert property (win_r[31] == 1'b0 && win_r[0] == 1'b0)
        else $error("edge window enable set");
    a_fwd_needs_mode: assert property (io_fwd_pci |-> $past(mode_r) == `BAR_MODE_INCLUDE && $past(io_req_valid))
        else $error("forwarded outside include mode");
    a_fwd_enabled_win: assert property (io_req_valid && win_r[win_idx(io_req_addr)] && mode_r == `BAR_MODE_INCLUDE |=> io_fwd_pci)
        else $error("enabled window not forwarded");
    a_host_log_load: assert property (host_err_evt && host_err_self |=> info_r[0] && host_log_r == $past(host_err_addr))
        else $error("host error address not logged");
    a_pci_log_load: assert property (pci_err_evt && pci_err_self |=> info_r[1] && pci_log_r == $past(pci_err_addr))
        else $error("pci error address not logged");
    a_foreign_host: assert property (host_err_evt && !host_err_self |=> info_r[2] && $stable(host_log_r))
        else $error("foreign host error not flagged");
    a_foreign_pci: assert property (pci_err_evt && !pci_err_self |=> info_r[3] && $stable(pci_log_r))
        else $error("foreign pci error not flagged");
    a_log_hold: assert property (!host_err_evt && !pci_err_evt |=> $stable(host_log_r) && $stable(pci_log_r))
        else $error("error log changed without error");
    a_fbb_write: assert property (we_fbb |=> host_fbb_en == $past(hwdata[0]))
        else $error("back-to-back enable not written");
    a_sts_clear: assert property ((we_sts || cmd_clear) && pci_sts_evt == 8'h00 |=> sts_r == 8'h00)
        else $error("pci status not cleared");
    a_sts_event: assert property (pci_sts_evt[0] |=> sts_r[0])
        else $error("pci status event lost");
    a_mlt_low_zero: assert property (master_latency[2:0] == 3'h0 && target_latency[1:0] == 2'h0)
        else $error("hardwired latency bits set");
    a_bus_wait: assert property (take |=> !hreadyout ##1 hreadyout)
        else $error("bus slave wait state wrong");

    c_host_log: cover property (host_err_evt && host_err_self ##1 take && !hwrite);
    c_forward: cover property (io_fwd_pci);
    c_status_clear: cover property (sts_r != 8'h00 ##1 we_sts);
    c_cmd_clear: cover property (cmd_clear && info_r != 4'h0);

endmodule

`default_nettype wire

// >>> bar_far_model.sv
// Far-side model: host-bus and PCI agents that report errors, status events and I/O requests.
`timescale 1ns/100ps
`default_nettype none
module bar_far_model (
    // Clock.
    input wire logic clock,
    // Error reports of both buses.
    output logic host_err_evt,
    output logic host_err_self,
    output logic [31:0] host_err_addr,
    output logic pci_err_evt,
    output logic pci_err_self,
    output logic [31:0] pci_err_addr,
    // Status events and processor I/O requests.
    output logic [7:0] pci_sts_evt,
    output logic io_req_valid,
    output logic [31:0] io_req_addr
);
    // Everything quiet at time zero.
    initial begin
        {host_err_evt, host_err_self, host_err_addr, pci_err_evt, pci_err_self} = '0;
        {pci_err_addr, pci_sts_evt, io_req_valid, io_req_addr} = '0;
    end

    // One error report for one cycle; released lines show the inverse so stale values never pass.
    task automatic report(input logic pci, input logic self, input logic [31:0] a);
        @(posedge clock);
        {host_err_evt, host_err_self, host_err_addr} <= pci ? {1'b0, ~self, ~a} : {1'b1, self, a};
        {pci_err_evt, pci_err_self, pci_err_addr} <= pci ? {1'b1, self, a} : {1'b0, ~self, ~a};
        @(posedge clock);
        {host_err_evt, host_err_self, host_err_addr} <= {1'b0, ~self, ~a};
        {pci_err_evt, pci_err_self, pci_err_addr} <= {1'b0, ~self, ~a};
    endtask

    // One cycle of status event pulses.
    task automatic status(input logic [7:0] v);
        @(posedge clock);
        pci_sts_evt <= v;
        @(posedge clock);
        pci_sts_evt <= 8'h00;
    endtask

    // One I/O request pulse; the address is scrambled once the request has gone.
    task automatic io_req(input logic [31:0] a);
        @(posedge clock);
        io_req_valid <= 1'b1;
        io_req_addr <= a;
        @(posedge clock);
        io_req_valid <= 1'b0;
        io_req_addr <= ~a;
    endtask
endmodule
`default_nettype wire

// >>> tb_top.sv
// Self-checking testbench of the bridge auxiliary register bank.
`timescale 1ns/100ps
`default_nettype none
`include "bar_map.svh"
module tb_top import bar_pkg::*;;
    // Clock, reset and bus master signals.
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = '0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = '0;
    logic hreadyout, hresp, host_err_evt, host_err_self, pci_err_evt, pci_err_self, io_req_valid;
    logic [31:0] hrdata, host_err_addr, pci_err_addr, io_req_addr;
    logic [7:0] pci_sts_evt, master_latency;
    // Control outputs of the bank.
    logic io_fwd_valid, io_fwd_pci, host_fbb_en, target_latency_en;
    logic [31:0] host_req_mask, pci_req_mask, cfg_addr, port_wdata;
    logic [6:0] arb_priority, pci_ctl, target_latency;
    logic [1:0] arb_perf;
    logic [2:0] port_wr;
    // Expected results, waiting for the watcher.
    logic [31:0] exp_q[$];
    logic [31:0] fwd_q[$];
    logic rd_ph = 1'b0;
    int n_fail = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [31:0] a, b, d;
    // Stored value of each writable register after the random pass.
    logic [31:0] exp_r [13];
    // Writable registers and the bits of each that store.
    localparam logic [11:0] OFFS [13] = '{12'h05C, 12'h060, 12'h064, 12'h800, 12'h804, 12'h808,
        12'h80C, 12'h81C, 12'h820, 12'h824, 12'h830, 12'h810, 12'h828};
    localparam logic [31:0] MSKS [13] = '{32'h00000001, 32'h7FFFFFFE, 32'hFFFFFFFF, 32'hFFFFFFFF,
        32'hFFFFFFFF, 32'h0000007F, 32'h00000003, 32'h000000F8, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h000000FC,
        32'h0000006F, 32'hFFFFFFFF};

    always #5 clock = ~clock;

    bar_regs dut_u (.clock, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
        .hreadyout, .hresp, .hrdata, .host_err_evt, .host_err_self, .host_err_addr, .pci_err_evt,
        .pci_err_self, .pci_err_addr, .pci_sts_evt, .io_req_valid, .io_req_addr, .io_fwd_valid,
        .io_fwd_pci, .host_fbb_en, .host_req_mask, .pci_req_mask, .arb_priority, .arb_perf, .pci_ctl,
        .master_latency, .target_latency_en, .target_latency, .cfg_addr, .port_wr, .port_wdata);
    bar_far_model far_u (.clock, .host_err_evt, .host_err_self, .host_err_addr, .pci_err_evt,
        .pci_err_self, .pci_err_addr, .pci_sts_evt, .io_req_valid, .io_req_addr);

    // Compares one value and counts the outcome.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // One single AHB-Lite transfer; a read notes its expected data for the watcher.
    task automatic bus(input logic w, input logic [11:0] off, input logic [31:0] dat);
        @(posedge clock);
        hsel <= 1'b1;
        haddr <= {20'h00000, off};
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge clock iff hreadyout);
        htrans <= 2'h0;
        hwdata <= w ? dat : ~dat;
        if (!w) exp_q.push_back(dat);
        @(posedge clock iff hreadyout);
    endtask

    // Watcher: takes the oldest note whenever read data or a forward decision appears.
    always @(posedge clock) begin
        if (rd_ph && hreadyout) check(hrdata, exp_q.pop_front());
        if (hreadyout) rd_ph <= hsel && htrans[1] && !hwrite;
        if (io_fwd_valid) check({31'h0, io_fwd_pci}, fwd_q.pop_front());
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            give_verdict();
        end
    end

    // Main sequence.
    initial begin
        void'($urandom(32'hE32A));
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        bus(0, `BAR_OFF_FEATURE, 32'h1);
        bus(0, `BAR_OFF_FBB, 32'h0);
        check({31'h0, host_fbb_en}, 32'h0);
        // Random data into every writable register but the data ports, mode control, status and command; only storing bits read back.
        for (int i = 0; i < 13; i++) begin
            d = $urandom;
            exp_r[i] = d & MSKS[i];
            bus(1, OFFS[i], d);
            bus(0, OFFS[i], exp_r[i]);
        end
        // The control outputs carry the stored register contents.
        check(cfg_addr, exp_r[2]);
        check(host_req_mask, exp_r[3]);
        check(pci_req_mask, exp_r[4]);
        check({25'h0, arb_priority}, exp_r[5]);
        check({30'h0, arb_perf}, exp_r[6]);
        check({24'h0, master_latency}, exp_r[7]);
        check({24'h0, target_latency_en, target_latency}, exp_r[10]);
        check({25'h0, pci_ctl}, exp_r[11]);
        bus(1, `BAR_OFF_FEATURE, 32'h0);
        bus(0, `BAR_OFF_FEATURE, 32'h1);
        bus(1, 12'h818, 32'hFFFFFFFF);
        bus(0, 12'h818, 32'h0);
        check({31'h0, hresp}, 32'h0);
        bus(1, `BAR_OFF_FBB, 32'h1);
        check({31'h0, host_fbb_en}, 32'h1);
        // The three data ports pass their write data on.
        for (int i = 0; i < 3; i++) begin
            d = $urandom;
            bus(1, 12'h068 + 12'(i * 4), d);
            check(port_wdata, d);
            check({29'h0, port_wr}, 32'h1 << i);
            bus(0, 12'h068 + 12'(i * 4), d);
        end
        // Own and foreign errors on both buses, then a clear command.
        a = $urandom;
        b = $urandom;
        far_u.report(1'b0, 1'b1, a);
        bus(0, `BAR_OFF_ERR_INFO, 32'h1);
        far_u.report(1'b0, 1'b0, b);
        far_u.report(1'b1, 1'b0, a);
        bus(0, `BAR_OFF_ERR_INFO, 32'hD);
        far_u.report(1'b1, 1'b1, b);
        bus(1, `BAR_OFF_HOST_ERR, ~a);
        bus(0, `BAR_OFF_HOST_ERR, a);
        bus(0, `BAR_OFF_PCI_ERR, b);
        bus(0, `BAR_OFF_ERR_INFO, 32'hF);
        bus(1, `BAR_OFF_COMMAND, {28'h0, `BAR_CMD_CLEAR});
        bus(0, `BAR_OFF_ERR_INFO, 32'h0);
        bus(0, `BAR_OFF_HOST_ERR, a);
        // Status events are cleared by a write and by the clear command.
        far_u.status(8'hFF);
        bus(0, `BAR_OFF_PCI_STS, 32'h1BF);
        bus(1, `BAR_OFF_PCI_STS, 32'h0);
        bus(0, `BAR_OFF_PCI_STS, 32'h120);
        far_u.status(8'h11);
        bus(1, `BAR_OFF_COMMAND, {28'h0, `BAR_CMD_CLEAR});
        bus(0, `BAR_OFF_PCI_STS, 32'h120);
        // Forwarding is refused while the mode is off, then tried in every window.
        bus(1, `BAR_OFF_IO_WIN, 32'hFFFFFFFF);
        for (int m = 0; m < 4; m++) begin
            bus(1, `BAR_OFF_MODE_CTL, m);
            fwd_q.push_back({31'h0, m == 1});
            far_u.io_req(32'h02800000);
        end
        bus(1, `BAR_OFF_MODE_CTL, {30'h0, `BAR_MODE_INCLUDE});
        for (int p = 0; p < 2; p++) begin
            d = p ? $urandom : 32'hFFFFFFFF;
            bus(1, `BAR_OFF_IO_WIN, d);
            for (int w = 0; w < 32; w++) begin
                fwd_q.push_back({31'h0, d[w] && w != 0 && w != 31});
                far_u.io_req(($urandom & 32'hF07FFFFF) | (w << 23));
            end
        end
        // The reset command returns the mode to off.
        bus(1, `BAR_OFF_COMMAND, {28'h0, `BAR_CMD_RESET});
        fwd_q.push_back(32'h0);
        far_u.io_req(32'h02800000 | (d & 32'h0));
        repeat (3) @(posedge clock);
        // Every noted read and forward decision must have been seen.
        check(exp_q.size(), 32'h0);
        check(fwd_q.size(), 32'h0);
        give_verdict();
    end
endmodule
`default_nettype wire
